// [perf_event_select_sources_defs.svh]
`ifndef PERF_EVENT_SELECT_SOURCES_DEFS_SVH
`define PERF_EVENT_SELECT_SOURCES_DEFS_SVH

// ==========================================================
// Sizes
`define PE_NUM_CNT       10
`define PE_EVNUM_W       7
`define PE_IRQ_W         64
`define PE_NUM_INTSEL    4
`define PE_RXF_LVL_W     9
`define PE_SQ_ENTRIES    8
`define PE_INQ_ENTRY_A   0
`define PE_INQ_ENTRY_B   6
`define PE_OUTQ_ENTRY    0

// ==========================================================
// Reference events, open to every counter except its own carry event
`define PE_REF_CHAIN_BASE 1
`define PE_REF_IRQ_TOTAL  26
`define PE_REF_INQ1       54
`define PE_REF_OUTQ1      55
`define PE_REF_INQ2       56
`define PE_REF_OUTQ2      57
`define PE_REF_INQ3       58
`define PE_REF_OUTQ3      59
`define PE_REF_LIMIT      64

// ==========================================================
// Counter-specific events: {counter, event number}
`define EVK_IRQ_WAIT     {4'h8, 7'h7E}
`define EVK_IRQ_SERVICE  {4'h2, 7'h53}
`define EVK_INTSEL0      {4'h1, 7'h78}
`define EVK_INTSEL1      {4'h3, 7'h7B}
`define EVK_INTSEL2      {4'h5, 7'h77}
`define EVK_INTSEL3      {4'h6, 7'h7C}
`define EVK_PCI_IN_READ  {4'h1, 7'h7E}
`define EVK_PCI_TOTAL    {4'h7, 7'h5D}
`define EVK_P1_IN_RD     {4'h8, 7'h77}
`define EVK_P1_IN_WR     {4'h9, 7'h65}
`define EVK_P1_IN_DATA   {4'h5, 7'h7C}
`define EVK_P1_OUT_RD    {4'h6, 7'h7E}
`define EVK_P1_OUT_WR    {4'h7, 7'h7D}
`define EVK_P1_OUT_DATA  {4'h8, 7'h7C}
`define EVK_P2_IN_RD     {4'h8, 7'h46}
`define EVK_P2_IN_WR     {4'h9, 7'h40}
`define EVK_P2_IN_DATA   {4'h5, 7'h4A}
`define EVK_P2_OUT_RD    {4'h6, 7'h4A}
`define EVK_P2_OUT_WR    {4'h7, 7'h49}
`define EVK_P2_OUT_DATA  {4'h8, 7'h48}
`define EVK_P3_IN_RD     {4'h8, 7'h47}
`define EVK_P3_IN_WR     {4'h9, 7'h41}
`define EVK_P3_IN_DATA   {4'h5, 7'h4B}
`define EVK_P3_OUT_RD    {4'h6, 7'h4B}
`define EVK_P3_OUT_WR    {4'h7, 7'h53}
`define EVK_P3_OUT_DATA  {4'h8, 7'h49}
`define EVK_E1_RXF_Q1    {4'h5, 7'h6E}
`define EVK_E1_RXF_Q2    {4'h6, 7'h71}
`define EVK_E1_RXF_Q3    {4'h7, 7'h6E}
`define EVK_E1_RXF_FULL  {4'h8, 7'h6E}
`define EVK_E3_RXF_Q1    {4'h9, 7'h61}
`define EVK_E3_RXF_Q2    {4'h1, 7'h6D}
`define EVK_E3_RXF_Q3    {4'h2, 7'h74}
`define EVK_E3_RXF_FULL  {4'h3, 7'h76}
`define EVK_TRIG_IN      {4'h3, 7'h7D}
`define EVK_UART0_BAUD   {4'h1, 7'h7F}
`define EVK_UART1_BAUD   {4'h5, 7'h7F}

`endif

// [perf_event_pkg.sv]
`include "perf_event_select_sources_defs.svh"

package perf_event_pkg;
    typedef logic [`PE_EVNUM_W-1:0] event_num_t;

    typedef struct packed {
        logic                     pending_unacked;
        logic                     in_service;
        logic                     serviced;
        logic [`PE_IRQ_W-1:0]     irq_in_service;
        logic [`PE_IRQ_W-1:0]     irq_prio_nonzero;
    } irq_src_s;

    typedef struct packed {
        logic                     in_rd;
        logic                     in_wr;
        logic                     in_data;
        logic                     out_rd;
        logic                     out_wr;
        logic                     out_data;
        logic [`PE_SQ_ENTRIES-1:0] inbound_static_queue;
        logic [`PE_SQ_ENTRIES-1:0] outbound_static_queue;
    } pcie_src_s;

    typedef struct packed {
        logic                     in_mem_read;
        logic                     in_mem_readline;
        logic                     in_mem_readmult;
        logic                     trans_32;
        logic                     trans_64;
    } pci_src_s;

    typedef struct packed {
        logic [`PE_RXF_LVL_W-1:0] rx_fifo_level;
    } eth_src_s;
endpackage

// [perf_event_select_sources.sv]
`timescale 1ns/10ps
`include "perf_event_select_sources_defs.svh"

// Behaviour
// - Counter MSB falling edge gives chaining event
// - External trigger counts every asserted cycle
// - PCIe reads and writes give one pulse
// - PCIe data events active every data beat
// - Port two outbound write on counter seven
// - Interrupt wait active while unacknowledged
// - Interrupt service active while servicing
// - Four masked interrupt-select events
// - One total pulse per serviced interrupt
// - Receive FIFO quarter, half, three-quarter, full
// - Inbound queue entry 0 or 6 lifetime
// - Outbound queue entry 0 lifetime
// - PCI inbound read counts all read types
// - PCI total counts 32- and 64-bit
module perf_event_select_sources
    import perf_event_pkg::*;
#(
    parameter int CNT_W     = 32,
    parameter int RXF_DEPTH = 256
) (
    // Clock and reset
    input  wire logic                                  i_clk_sys,
    input  wire logic                                  i_rstn,
    // Event selection per counter
    input  wire event_num_t [`PE_NUM_CNT-1:0]          i_event_sel,
    input  wire logic [`PE_NUM_INTSEL-1:0][`PE_IRQ_W-1:0] i_interrupt_select_mask_pair,
    // Event sources
    input  wire irq_src_s                              i_irq,
    input  wire pci_src_s                              i_pci,
    input  wire pcie_src_s [2:0]                       i_pcie,
    input  wire eth_src_s [1:0]                        i_eth,
    input  wire logic [1:0]                            i_uart_baud,
    input  wire logic                                  i_trig_in,
    // Counters
    output logic [`PE_NUM_CNT-1:0]                     o_event,
    output logic [`PE_NUM_CNT-1:0][CNT_W-1:0]          o_count
);

    // ==========================================================
    // Parameter checks
    if (CNT_W < 2) begin : g_bad_cnt_w
        $error("CNT_W too small");
    end
    if (RXF_DEPTH < 4 || RXF_DEPTH >= (1 << `PE_RXF_LVL_W)) begin : g_bad_rxf_depth
        $error("RXF_DEPTH out of range");
    end

    localparam logic [`PE_RXF_LVL_W-1:0] RXF_Q1   = `PE_RXF_LVL_W'(RXF_DEPTH / 4);
    localparam logic [`PE_RXF_LVL_W-1:0] RXF_Q2   = `PE_RXF_LVL_W'(RXF_DEPTH / 2);
    localparam logic [`PE_RXF_LVL_W-1:0] RXF_Q3   = `PE_RXF_LVL_W'((RXF_DEPTH * 3) / 4);
    localparam logic [`PE_RXF_LVL_W-1:0] RXF_FULL = `PE_RXF_LVL_W'(RXF_DEPTH);

    // ==========================================================
    // Trigger pin synchroniser
    logic trig_meta;
    logic trig_sync;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
        end else begin
            trig_meta <= i_trig_in;
            trig_sync <= trig_meta;
        end
    end

    // ==========================================================
    // Derived source events
    logic [`PE_NUM_INTSEL-1:0] int_select;
    logic [2:0]                inq_life;
    logic [2:0]                outq_life;
    logic [1:0][3:0]           rxf_thresh;
    logic                      pci_in_read;
    logic                      pci_total;

    // Masked or zero-priority requests never count as acknowledged
    genvar j;
    generate
        for (j = 0; j < `PE_NUM_INTSEL; j++) begin : g_intsel
            assign int_select[j] = |(i_irq.irq_in_service & i_irq.irq_prio_nonzero
                                     & ~i_interrupt_select_mask_pair[j]);
        end
        for (j = 0; j < 3; j++) begin : g_pcie
            assign inq_life[j] = i_pcie[j].inbound_static_queue[`PE_INQ_ENTRY_A]
                               | i_pcie[j].inbound_static_queue[`PE_INQ_ENTRY_B];
            assign outq_life[j] = i_pcie[j].outbound_static_queue[`PE_OUTQ_ENTRY];
        end
        for (j = 0; j < 2; j++) begin : g_eth
            assign rxf_thresh[j][0] = i_eth[j].rx_fifo_level > RXF_Q1;
            assign rxf_thresh[j][1] = i_eth[j].rx_fifo_level > RXF_Q2;
            assign rxf_thresh[j][2] = i_eth[j].rx_fifo_level > RXF_Q3;
            assign rxf_thresh[j][3] = i_eth[j].rx_fifo_level == RXF_FULL;
        end
    endgenerate

    assign pci_in_read = i_pci.in_mem_read | i_pci.in_mem_readline | i_pci.in_mem_readmult;
    assign pci_total   = i_pci.trans_32 | i_pci.trans_64;

    // ==========================================================
    // Carry-out chaining
    logic [`PE_NUM_CNT-1:0] msb_prev;
    logic [`PE_NUM_CNT-1:0] carry;
    logic [`PE_REF_LIMIT-1:0] ref_ev;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            msb_prev <= '0;
        end else begin
            for (int k = 0; k < `PE_NUM_CNT; k++) begin
                msb_prev[k] <= o_count[k][CNT_W-1];
            end
        end
    end

    always_comb begin
        ref_ev = '0;
        for (int k = 0; k < `PE_NUM_CNT; k++) begin
            carry[k] = msb_prev[k] & ~o_count[k][CNT_W-1];
            ref_ev[`PE_REF_CHAIN_BASE + k] = carry[k];
        end
        ref_ev[`PE_REF_IRQ_TOTAL] = i_irq.serviced;
        ref_ev[`PE_REF_INQ1]      = inq_life[0];
        ref_ev[`PE_REF_OUTQ1]     = outq_life[0];
        ref_ev[`PE_REF_INQ2]      = inq_life[1];
        ref_ev[`PE_REF_OUTQ2]     = outq_life[1];
        ref_ev[`PE_REF_INQ3]      = inq_life[2];
        ref_ev[`PE_REF_OUTQ3]     = outq_life[2];
    end

    // ==========================================================
    // Per-counter selection and counting
    logic [`PE_NUM_CNT-1:0] next_event;

    genvar k;
    generate
        for (k = 0; k < `PE_NUM_CNT; k++) begin : g_cnt
            logic [10:0] key;
            assign key = {4'(k), i_event_sel[k]};

            always_comb begin
                next_event[k] = 1'b0;
                if (i_event_sel[k] < `PE_EVNUM_W'(`PE_REF_LIMIT)) begin
                    // Own carry would feed back on itself; held at zero
                    if (i_event_sel[k] != `PE_EVNUM_W'(`PE_REF_CHAIN_BASE + k)) begin
                        next_event[k] = ref_ev[i_event_sel[k][5:0]];
                    end
                end else begin
                    case (key)
                        `EVK_IRQ_WAIT:    next_event[k] = i_irq.pending_unacked;
                        `EVK_IRQ_SERVICE: next_event[k] = i_irq.in_service;
                        `EVK_INTSEL0:     next_event[k] = int_select[0];
                        `EVK_INTSEL1:     next_event[k] = int_select[1];
                        `EVK_INTSEL2:     next_event[k] = int_select[2];
                        `EVK_INTSEL3:     next_event[k] = int_select[3];
                        `EVK_PCI_IN_READ: next_event[k] = pci_in_read;
                        `EVK_PCI_TOTAL:   next_event[k] = pci_total;
                        `EVK_P1_IN_RD:    next_event[k] = i_pcie[0].in_rd;
                        `EVK_P1_IN_WR:    next_event[k] = i_pcie[0].in_wr;
                        `EVK_P1_IN_DATA:  next_event[k] = i_pcie[0].in_data;
                        `EVK_P1_OUT_RD:   next_event[k] = i_pcie[0].out_rd;
                        `EVK_P1_OUT_WR:   next_event[k] = i_pcie[0].out_wr;
                        `EVK_P1_OUT_DATA: next_event[k] = i_pcie[0].out_data;
                        `EVK_P2_IN_RD:    next_event[k] = i_pcie[1].in_rd;
                        `EVK_P2_IN_WR:    next_event[k] = i_pcie[1].in_wr;
                        `EVK_P2_IN_DATA:  next_event[k] = i_pcie[1].in_data;
                        `EVK_P2_OUT_RD:   next_event[k] = i_pcie[1].out_rd;
                        `EVK_P2_OUT_WR:   next_event[k] = i_pcie[1].out_wr;
                        `EVK_P2_OUT_DATA: next_event[k] = i_pcie[1].out_data;
                        `EVK_P3_IN_RD:    next_event[k] = i_pcie[2].in_rd;
                        `EVK_P3_IN_WR:    next_event[k] = i_pcie[2].in_wr;
                        `EVK_P3_IN_DATA:  next_event[k] = i_pcie[2].in_data;
                        `EVK_P3_OUT_RD:   next_event[k] = i_pcie[2].out_rd;
                        `EVK_P3_OUT_WR:   next_event[k] = i_pcie[2].out_wr;
                        `EVK_P3_OUT_DATA: next_event[k] = i_pcie[2].out_data;
                        `EVK_E1_RXF_Q1:   next_event[k] = rxf_thresh[0][0];
                        `EVK_E1_RXF_Q2:   next_event[k] = rxf_thresh[0][1];
                        `EVK_E1_RXF_Q3:   next_event[k] = rxf_thresh[0][2];
                        `EVK_E1_RXF_FULL: next_event[k] = rxf_thresh[0][3];
                        `EVK_E3_RXF_Q1:   next_event[k] = rxf_thresh[1][0];
                        `EVK_E3_RXF_Q2:   next_event[k] = rxf_thresh[1][1];
                        `EVK_E3_RXF_Q3:   next_event[k] = rxf_thresh[1][2];
                        `EVK_E3_RXF_FULL: next_event[k] = rxf_thresh[1][3];
                        `EVK_TRIG_IN:     next_event[k] = trig_sync;
                        `EVK_UART0_BAUD:  next_event[k] = i_uart_baud[0];
                        `EVK_UART1_BAUD:  next_event[k] = i_uart_baud[1];
                        default:          next_event[k] = 1'b0;
                    endcase
                end
            end

            // One increment per active cycle, two cycles behind the source
            always_ff @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    o_event[k] <= 1'b0;
                    o_count[k] <= '0;
                end else begin
                    o_event[k] <= next_event[k];
                    if (o_event[k]) begin
                        o_count[k] <= o_count[k] + CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    a_count_step: assert property (o_event[4] |=> o_count[4] == $past(o_count[4]) + CNT_W'(1))
        else $error("counter did not step on routed event");
    a_chain_pulse: assert property ($fell(o_count[0][CNT_W-1]) |-> carry[0] && ref_ev[1])
        else $error("carry-out not raised on MSB fall");
    a_own_chain_off: assert property (i_event_sel[1] == 7'h02 |=> !o_event[1])
        else $error("own carry reached counter");
    // Two synchroniser stages plus the event register: seen three edges after the pin
    a_trig_latency: assert property ($rose(i_trig_in) ##2 i_event_sel[3] == 7'h7D |=> o_event[3])
        else $error("trigger event not seen three cycles after pin");
    a_pcie2_outwr: assert property (i_event_sel[7] == 7'h49 && i_pcie[1].out_wr |=> o_event[7])
        else $error("port two outbound write lost");
    a_pcie1_data: assert property (i_event_sel[5] == 7'h7C |=> o_event[5] == $past(i_pcie[0].in_data))
        else $error("inbound data beat mismatch");
    a_irq_wait: assert property (i_event_sel[8] == 7'h7E |=> o_event[8] == $past(i_irq.pending_unacked))
        else $error("wait event mismatch");
    a_irq_service: assert property (i_event_sel[2] == 7'h53 && i_irq.in_service |=> o_event[2])
        else $error("service event lost");
    a_intsel_mask: assert property (i_event_sel[1] == 7'h78 && ~|(i_irq.irq_prio_nonzero & i_irq.irq_in_service)
                                    |=> !o_event[1])
        else $error("zero-priority interrupt counted");
    a_irq_total: assert property (i_event_sel[4] == 7'h1A |=> o_event[4] == $past(i_irq.serviced))
        else $error("total interrupt pulse mismatch");
    a_rxf_full: assert property (i_event_sel[8] == 7'h6E && i_eth[0].rx_fifo_level == RXF_FULL |=> o_event[8])
        else $error("full FIFO not counted");
    a_inq_life: assert property (i_event_sel[0] == 7'h36 |=> o_event[0] == $past(inq_life[0]))
        else $error("inbound queue lifetime mismatch");
    a_pci_read: assert property (i_event_sel[1] == 7'h7E && i_pci.in_mem_readline |=> o_event[1])
        else $error("read line not counted");

    c_chain: cover property (carry[0] ##1 o_event[1]);
    c_trig: cover property (i_event_sel[3] == 7'h7D && o_event[3] [*3]);
    c_rxf: cover property (i_event_sel[5] == 7'h6E && o_event[5]);
    c_inq: cover property (i_event_sel[0] == 7'h3A && o_event[0]);

endmodule // perf_event_select_sources

// [event_source_model.sv]
`timescale 1ns/10ps
`include "perf_event_select_sources_defs.svh"

// ==========================================================
// On-chip event sources, driven from one activity vector
module event_source_model
    import perf_event_pkg::*;
(
    // Activity requests from the bench
    input  wire logic [41:0]                         i_act,
    input  wire logic [1:0][`PE_RXF_LVL_W-1:0]       i_lvl,
    // Source lines toward the selector
    output irq_src_s                                 o_irq,
    output pci_src_s                                 o_pci,
    output pcie_src_s [2:0]                          o_pcie,
    output eth_src_s [1:0]                           o_eth,
    output logic [1:0]                               o_uart_baud,
    output logic                                     o_trig_in
);
    // Idle event lines sit low; a held bit means back-to-back events
    always_comb begin
        int b;
        b = 0;
        o_irq = '0;
        o_irq.pending_unacked = i_act[0];
        o_irq.in_service = i_act[1];
        o_irq.serviced = i_act[2];
        o_irq.irq_in_service[5] = i_act[3];
        o_irq.irq_prio_nonzero[5] = i_act[4];
        o_pci = {i_act[5], i_act[6], i_act[7], i_act[8], i_act[9]};
        for (int p = 0; p < 3; p++) begin
            b = 10 + 9 * p;
            o_pcie[p] = '0;
            o_pcie[p].in_rd = i_act[b];
            o_pcie[p].in_wr = i_act[b + 1];
            o_pcie[p].in_data = i_act[b + 2];
            o_pcie[p].out_rd = i_act[b + 3];
            o_pcie[p].out_wr = i_act[b + 4];
            o_pcie[p].out_data = i_act[b + 5];
            o_pcie[p].inbound_static_queue[0] = i_act[b + 6];
            o_pcie[p].inbound_static_queue[6] = i_act[b + 7];
            o_pcie[p].outbound_static_queue[0] = i_act[b + 8];
        end
        o_uart_baud = i_act[38:37];
        o_trig_in = i_act[39];
        for (int e = 0; e < 2; e++) begin
            o_eth[e].rx_fifo_level = i_act[40 + e] ? i_lvl[e] : '0;
        end
    end
endmodule // event_source_model

// [testbench.sv]
`timescale 1ns/10ps
`include "perf_event_select_sources_defs.svh"

module testbench
    import perf_event_pkg::*;
;
    localparam int CW    = 4;
    localparam int DEPTH = 16;

    logic                                  i_clk_sys;
    logic                                  i_rstn;
    event_num_t [`PE_NUM_CNT-1:0]          sel;
    logic [`PE_NUM_INTSEL-1:0][`PE_IRQ_W-1:0] mask;
    logic [41:0]                           act;
    logic [1:0][`PE_RXF_LVL_W-1:0]         lvl;
    irq_src_s                              irq;
    pci_src_s                              pci;
    pcie_src_s [2:0]                       pcie;
    eth_src_s [1:0]                        eth;
    logic [1:0]                            uart;
    logic                                  trig;
    logic [`PE_NUM_CNT-1:0]                o_event;
    logic [`PE_NUM_CNT-1:0][CW-1:0]        o_count;
    int                                    n_fail = 0;
    int                                    check_count = 0;

    always #5 i_clk_sys = ~i_clk_sys;

    perf_event_select_sources #(.CNT_W(CW), .RXF_DEPTH(DEPTH)) u_perf_event_select_sources (
        .i_clk_sys (i_clk_sys), .i_rstn (i_rstn), .i_event_sel (sel),
        .i_interrupt_select_mask_pair (mask), .i_irq (irq), .i_pci (pci), .i_pcie (pcie),
        .i_eth (eth), .i_uart_baud (uart), .i_trig_in (trig), .o_event (o_event), .o_count (o_count));

    event_source_model u_event_source_model (
        .i_act (act), .i_lvl (lvl), .o_irq (irq), .o_pci (pci), .o_pcie (pcie),
        .o_eth (eth), .o_uart_baud (uart), .o_trig_in (trig));

    // ==========================================================
    // Reporting
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // ==========================================================
    // Route one source to counter k, hold it n cycles, judge event and count
    task automatic measure(input int k, input int ev, input int bit_i, input int n, input int lat, input int exp);
        logic [CW-1:0] c0;
        logic [CW-1:0] d;
        logic [CW-1:0] e;
        e = exp[CW-1:0];
        @(negedge i_clk_sys);
        sel[k] = event_num_t'(ev);
        repeat (2) @(negedge i_clk_sys);
        c0 = o_count[k];
        act[bit_i] = 1'b1;
        for (int i = 1; i <= n + lat + 2; i++) begin
            @(negedge i_clk_sys);
            if (i == lat) check("routed event", 32'(o_event[k]), 32'(exp != 0));
            if (i == n) act[bit_i] = 1'b0;
        end
        d = o_count[k] - c0;
        check("count delta", 32'(d), 32'(e));
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check("events after reset", 32'(o_event), 32'h0);
        for (int k = 0; k < `PE_NUM_CNT; k++) check("count after reset", 32'(o_count[k]), 32'h0);
    endtask

    task automatic t_irq();
        measure(8, 126, 0, 3, 1, 3);
        measure(2, 83, 1, 4, 1, 4);
        measure(4, `PE_REF_IRQ_TOTAL, 2, 3, 1, 3);
    endtask

    task automatic t_intsel();
        int cn [4] = '{1, 3, 5, 6};
        int ev [4] = '{120, 123, 119, 124};
        for (int s = 0; s < 4; s++) begin
            mask = '0;
            act[4] = 1'b1;
            measure(cn[s], ev[s], 3, 2, 1, 2);
            mask[s][5] = 1'b1;
            measure(cn[s], ev[s], 3, 2, 1, 0);
            mask = '0;
            act[4] = 1'b0;
            measure(cn[s], ev[s], 3, 2, 1, 0);
        end
    endtask

    task automatic t_pci();
        for (int b = 5; b < 8; b++) measure(1, 126, b, 2, 1, 2);
        for (int b = 8; b < 10; b++) measure(7, 93, b, 3, 1, 3);
    endtask

    task automatic t_pcie();
        int cn [6] = '{8, 9, 5, 6, 7, 8};
        int ev [3][6] = '{'{119, 101, 124, 126, 125, 124}, '{70, 64, 74, 74, 73, 72}, '{71, 65, 75, 75, 83, 73}};
        for (int p = 0; p < 3; p++) begin
            for (int j = 0; j < 6; j++) measure(cn[j], ev[p][j], 10 + 9 * p + j, 3, 1, 3);
            measure(0, 54 + 2 * p, 16 + 9 * p, 3, 1, 3);
            measure(0, 54 + 2 * p, 17 + 9 * p, 2, 1, 2);
            measure(0, 55 + 2 * p, 18 + 9 * p, 3, 1, 3);
        end
    endtask

    task automatic t_eth();
        int th [4] = '{DEPTH / 4, DEPTH / 2, 3 * DEPTH / 4, DEPTH - 1};
        int cn [2][4] = '{'{5, 6, 7, 8}, '{9, 1, 2, 3}};
        int ev [2][4] = '{'{110, 113, 110, 110}, '{97, 109, 116, 118}};
        for (int e = 0; e < 2; e++) begin
            for (int j = 0; j < 4; j++) begin
                lvl[e] = th[j][`PE_RXF_LVL_W-1:0];
                measure(cn[e][j], ev[e][j], 40 + e, 2, 1, 0);
                lvl[e] = th[j][`PE_RXF_LVL_W-1:0] + 1'b1;
                measure(cn[e][j], ev[e][j], 40 + e, 2, 1, 2);
            end
        end
    endtask

    task automatic t_misc();
        measure(3, 125, 39, 5, 3, 5);
        measure(1, 127, 37, 2, 1, 2);
        measure(5, 127, 38, 3, 1, 3);
    endtask

    task automatic t_chain();
        logic [CW-1:0] c1;
        logic [CW-1:0] d;
        // Counter 1 follows counter 0, never its own carry
        sel[1] = event_num_t'(`PE_REF_CHAIN_BASE);
        repeat (2) @(negedge i_clk_sys);
        c1 = o_count[1];
        // A full lap of counter 0: events every cycle, delta wraps to zero
        measure(0, `PE_REF_INQ1, 16, 1 << CW, 1, 1 << CW);
        repeat (3) @(negedge i_clk_sys);
        d = o_count[1] - c1;
        check("chained count", 32'(d), 32'h1);
        // Own carry selected: nothing may reach the counter
        measure(1, `PE_REF_CHAIN_BASE + 1, 16, 2, 1, 0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        i_clk_sys = 1'b0;
        i_rstn = 1'b0;
        sel = '0;
        mask = '0;
        act = '0;
        lvl = '0;
        repeat (2) @(negedge i_clk_sys);
        i_rstn = 1'b1;
        @(negedge i_clk_sys);
        t_reset();
        t_irq();
        t_intsel();
        t_pci();
        t_pcie();
        t_eth();
        t_misc();
        t_chain();
        give_verdict();
    end

    // Roughly thirty times the expected run length
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_fail++;
        give_verdict();
    end
endmodule // testbench
